/* File: design/tsc_pkg.sv */
// constants, register layout and state codes of the tuner serial control logic
// assumes a 25 MHz system clock and a two-wire link paced by the master
package tsc_pkg;

    // ==========================================================
    // bus addressing
    localparam logic [4:0] ADDR_HI_BITS = 5'h18;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    // ==========================================================
    // register bytes, index = byte number minus two
    localparam int NUM_REGS = 12;
    localparam logic [3:0] IDX_DIV_HI = 4'h0;
    localparam logic [3:0] IDX_DIV_LO = 4'h1;
    localparam logic [3:0] IDX_GAIN = 4'h2;
    localparam logic [3:0] IDX_REF = 4'h3;
    localparam logic [3:0] IDX_CTRL = 4'h4;
    localparam logic [3:0] IDX_FREF = 4'h5;
    localparam logic [3:0] IDX_FBW = 4'h7;
    localparam logic [3:0] IDX_LAST = 4'hb;
    localparam logic [3:0] IDX_PAST = 4'hc;
    localparam logic [3:0] IDX_PAIR_2 = 4'h0;
    localparam logic [3:0] IDX_PAIR_4 = 4'h2;
    localparam logic [3:0] IDX_PAIR_6 = 4'h4;
    localparam logic [3:0] IDX_PAIR_8 = 4'h6;
    localparam logic [3:0] IDX_PAIR_10 = 4'h8;
    localparam logic [3:0] IDX_PAIR_12 = 4'ha;

    // ==========================================================
    // field positions
    localparam int BIT_RF_GAIN = 5;
    localparam int BIT_PORT0 = 7;
    localparam int BIT_PD = 0;
    localparam int BIT_BYPASS = 1;
    localparam int W_DIV_HI = 7;
    localparam int W_REF_SEL = 5;
    localparam int W_FREF = 5;
    localparam int W_FBW = 6;
    localparam int W_DIV = 15;
    localparam int STAT_POR = 7;
    localparam int STAT_LOCK = 6;

    // ==========================================================
    // reset values, bypass enabled in the control byte
    localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {
        8'h00, 8'hf0, 8'h00, 8'he0, 8'h00, 8'hd0, 8'h00, 8'hc2, 8'h00, 8'h80, 8'h00, 8'h00};

    // ==========================================================
    // oscillator band thresholds on the divider value
    localparam logic [14:0] BAND_MID_MIN = 15'h1000;
    localparam logic [14:0] BAND_HI_MIN = 15'h3000;
    localparam logic [1:0] BAND_LO = 2'h0;
    localparam logic [1:0] BAND_MID = 2'h1;
    localparam logic [1:0] BAND_HI = 2'h2;

    // ==========================================================
    // link states
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_ACK = 6'h04,
        ST_WRITE = 6'h08,
        ST_READ = 6'h10,
        ST_RACK = 6'h20
    } tsc_state_t;

endpackage : tsc_pkg

/* File: design/tsc_sync.sv */
// two-stage synchroniser for a group of pin inputs
// assumes the inputs are asynchronous to clk
`timescale 1ns/100ps
`default_nettype none
module tsc_sync #(
    parameter int W = 1
) (
    input wire logic clk,           // system clock
    input wire logic reset,         // async reset, high
    input wire logic [W-1:0] d,     // raw pin levels
    output logic [W-1:0] q          // synchronised levels
);
    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
    } tsc_sync_t;

    tsc_sync_t s_r;
    tsc_sync_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.ff1 = d;
        s_nxt.ff2 = s_r.ff1;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.ff2;
endmodule // tsc_sync
`default_nettype wire

/* File: design/tsc_regs.sv */
// register byte store with even-pair sub-addressing
// assumes one write strobe per received data byte
`timescale 1ns/100ps
`default_nettype none
module tsc_regs
    import tsc_pkg::*;
(
    input wire logic clk,                       // system clock
    input wire logic reset,                     // async reset, high
    input wire logic wr_stb,                    // one-cycle byte strobe
    input wire logic wr_first,                  // first data byte of transfer
    input wire logic [7:0] wr_data,             // received byte
    output logic [NUM_REGS-1:0][7:0] regs       // stored bytes
);
    typedef struct packed {
        logic [NUM_REGS-1:0][7:0] bytes;
        logic [3:0] ptr;
    } tsc_regs_t;

    tsc_regs_t s_r;
    tsc_regs_t s_nxt;
    logic [3:0] idx;

    // first byte's leading bits pick the pair it starts
    function automatic logic [3:0] pair_of(input logic [7:0] b);
        if (!b[7]) return IDX_PAIR_2;
        if (!b[6]) return IDX_PAIR_4;
        case (b[5:4])
            2'h0: return IDX_PAIR_6;
            2'h1: return IDX_PAIR_8;
            2'h2: return IDX_PAIR_10;
            default: return IDX_PAIR_12;
        endcase
    endfunction

    always_comb begin
        s_nxt = s_r;
        idx = wr_first ? pair_of(wr_data) : s_r.ptr;
        if (wr_stb) begin
            // bytes past the last register are dropped; contents survive power-down
            if (idx <= IDX_LAST) begin
                s_nxt.bytes[idx] = wr_data;
                s_nxt.ptr = 4'(idx + 4'h1);
            end else begin
                s_nxt.ptr = IDX_PAST;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r.bytes <= REG_RESET;
            s_r.ptr <= IDX_PAIR_2;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign regs = s_r.bytes;
endmodule // tsc_regs
`default_nettype wire

/* File: design/tsc_ctrl.sv */
// top of the tuner serial control logic: two-wire slave, settings and lock report
// assumes scl/sda/straps/sleep/lock arrive asynchronously; the pad resolves sda from sda_oe
//
// Contract
// - address LSB zero writes, one reads
// - four addresses chosen by select levels
// - acknowledge address and every received byte
// - missing master ack ends read, releases
// - sleep pin OR power-down bit powers down
// - sleep leaves RF bypass untouched
// - one bit alone switches RF bypass
// - disabled bypass sits in power-down
// - bypass enabled from reset
// - one bit selects second RF gain step
// - five-bit filter reference divider, 4 to 27
// - six-bit filter width code, 0 to 62
// - fifteen-bit synthesizer divider ratio
// - reference divider selects among 29 ratios
// - oscillator band chosen automatically
// - eight-bit status byte, lock on pin too
// - write addresses c0 to c6, read plus one
// - status bit six shows lock
// - lock pin low after reset
`timescale 1ns/100ps
`default_nettype none
module tsc_ctrl
    import tsc_pkg::*;
(
    input wire logic clk,                       // 25 MHz system clock
    input wire logic reset,                     // async reset, high
    input wire logic scl_in,                    // link clock pin
    input wire logic sda_in,                    // data pin level
    output logic sda_out,                       // data drive value, always low
    output logic sda_oe,                        // high while pulling data low
    input wire logic id_level_hi,               // address select, upper level
    input wire logic id_level_lo,               // address select, lower level
    input wire logic sleep_in,                  // sleep pin, high sleeps
    input wire logic lock_in,                   // synthesizer lock detector
    output logic [W_DIV-1:0] synth_div,         // synthesizer divider ratio
    output logic [W_REF_SEL-1:0] ref_div_sel,   // reference divider ratio select
    output logic rf_gain_hi,                    // second RF gain stage step
    output logic [W_FREF-1:0] filter_ref_div,   // filter loop reference divider
    output logic [W_FBW-1:0] filter_width_code, // filter bandwidth code
    output logic power_down,                    // analogue sections powered down
    output logic bypass_en,                     // RF bypass on
    output logic bypass_pd,                     // RF bypass powered down
    output logic [1:0] lo_band_sel,             // oscillator band and harmonic select
    output logic lock_out,                      // lock pin
    output logic port0_on                       // switching port 0 on
);
    // ==========================================================
    // state
    typedef struct packed {
        tsc_state_t st;
        logic scl_q;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] tx;
        logic rw;
        logic ackd;
        logic first;
        logic rd_seen;
        logic por;
        logic sda_oe;
        logic sda_o;
        logic wr_stb;
        logic [7:0] wr_data;
        logic [W_DIV-1:0] synth_div;
        logic [W_REF_SEL-1:0] ref_div_sel;
        logic rf_gain_hi;
        logic [W_FREF-1:0] filter_ref_div;
        logic [W_FBW-1:0] filter_width_code;
        logic power_down;
        logic bypass_en;
        logic bypass_pd;
        logic [1:0] lo_band_sel;
        logic lock_out;
        logic port0_on;
        logic sda_q;
    } tsc_ctrl_t;

    tsc_ctrl_t s_r;
    tsc_ctrl_t s_nxt;

    // ==========================================================
    // pin synchronisers and register store
    logic [5:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic id_hi_s;
    logic id_lo_s;
    logic sleep_s;
    logic lock_s;
    logic [NUM_REGS-1:0][7:0] regs;

    tsc_sync #(
        .W(6)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .d({scl_in, sda_in, id_level_hi, id_level_lo, sleep_in, lock_in}),
        .q(pins_s)
    );

    assign {scl_s, sda_s, id_hi_s, id_lo_s, sleep_s, lock_s} = pins_s;

    tsc_regs u_regs (
        .clk(clk),
        .reset(reset),
        .wr_stb(s_r.wr_stb),
        .wr_first(s_r.first),
        .wr_data(s_r.wr_data),
        .regs(regs)
    );

    // ==========================================================
    // link events
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic addr_match;
    logic [7:0] status;

    // automatic band choice from the programmed divider
    function automatic logic [1:0] band_of(input logic [W_DIV-1:0] div);
        if (div >= BAND_HI_MIN) return BAND_HI;
        if (div >= BAND_MID_MIN) return BAND_MID;
        return BAND_LO;
    endfunction

    assign scl_rise = scl_s && !s_r.scl_q;
    assign scl_fall = !scl_s && s_r.scl_q;
    assign start_cond = scl_s && s_r.scl_q && s_r.sda_q && !sda_s;
    assign stop_cond = scl_s && s_r.scl_q && !s_r.sda_q && sda_s;
    assign addr_match = s_r.shift[7:1] == {ADDR_HI_BITS, id_hi_s, id_lo_s};

    always_comb begin
        status = 8'h00;
        status[STAT_POR] = s_r.por;
        status[STAT_LOCK] = lock_s;
    end

    // ==========================================================
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.scl_q = scl_s;
        s_nxt.sda_q = sda_s;
        s_nxt.wr_stb = 1'b0;
        s_nxt.sda_o = 1'b0;
        if (start_cond) begin
            s_nxt.st = ST_ADDR;
            s_nxt.cnt = 4'h0;
            s_nxt.sda_oe = 1'b0;
            s_nxt.first = 1'b1;
        end else if (stop_cond) begin
            s_nxt.st = ST_IDLE;
            s_nxt.sda_oe = 1'b0;
            if (s_r.rd_seen) begin
                s_nxt.por = 1'b0;
            end
            s_nxt.rd_seen = 1'b0;
        end else begin
            case (s_r.st)
                ST_IDLE: begin
                    s_nxt.sda_oe = 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        s_nxt.shift = {s_r.shift[6:0], sda_s};
                        s_nxt.cnt = 4'(s_r.cnt + 4'h1);
                    end else if (scl_fall && s_r.cnt == BYTE_BITS) begin
                        if (addr_match) begin
                            s_nxt.st = ST_ACK;
                            s_nxt.sda_oe = 1'b1;
                            s_nxt.rw = s_r.shift[0];
                        end else begin
                            s_nxt.st = ST_IDLE;
                        end
                    end
                end
                ST_WRITE: begin
                    if (scl_rise) begin
                        s_nxt.shift = {s_r.shift[6:0], sda_s};
                        s_nxt.cnt = 4'(s_r.cnt + 4'h1);
                    end else if (scl_fall && s_r.cnt == BYTE_BITS) begin
                        s_nxt.wr_stb = 1'b1;
                        s_nxt.wr_data = s_r.shift;
                        s_nxt.st = ST_ACK;
                        s_nxt.sda_oe = 1'b1;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        s_nxt.cnt = 4'h0;
                        if (s_r.wr_stb) begin
                            s_nxt.first = 1'b0;
                        end
                        if (s_r.rw) begin
                            s_nxt.tx = status;
                            s_nxt.sda_oe = !status[7];
                            s_nxt.st = ST_READ;
                            s_nxt.rd_seen = 1'b1;
                        end else begin
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.st = ST_WRITE;
                        end
                    end else if (s_r.wr_stb) begin
                        s_nxt.first = 1'b0;
                    end
                end
                ST_READ: begin
                    if (scl_fall) begin
                        if (s_r.cnt == LAST_BIT) begin
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.st = ST_RACK;
                        end else begin
                            s_nxt.tx = {s_r.tx[6:0], 1'b0};
                            s_nxt.sda_oe = !s_r.tx[6];
                            s_nxt.cnt = 4'(s_r.cnt + 4'h1);
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        s_nxt.ackd = !sda_s;
                    end else if (scl_fall) begin
                        if (s_r.ackd) begin
                            s_nxt.tx = status;
                            s_nxt.sda_oe = !status[7];
                            s_nxt.cnt = 4'h0;
                            s_nxt.st = ST_READ;
                        end else begin
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.st = ST_IDLE;
                        end
                    end
                end
                default: begin
                    s_nxt.st = ST_IDLE;
                    s_nxt.sda_oe = 1'b0;
                end
            endcase
        end

        // settings decoded from the register store and the sleep pin, lock pin copied from lock_s
        s_nxt.synth_div = {regs[IDX_DIV_HI][W_DIV_HI-1:0], regs[IDX_DIV_LO]};
        s_nxt.ref_div_sel = regs[IDX_REF][W_REF_SEL-1:0];
        s_nxt.port0_on = regs[IDX_REF][BIT_PORT0];
        s_nxt.rf_gain_hi = regs[IDX_GAIN][BIT_RF_GAIN];
        s_nxt.filter_ref_div = regs[IDX_FREF][W_FREF-1:0];
        s_nxt.filter_width_code = regs[IDX_FBW][W_FBW-1:0];
        s_nxt.power_down = sleep_s || regs[IDX_CTRL][BIT_PD];
        s_nxt.bypass_en = regs[IDX_CTRL][BIT_BYPASS];
        s_nxt.bypass_pd = !regs[IDX_CTRL][BIT_BYPASS];
        s_nxt.lo_band_sel = band_of(s_nxt.synth_div);
        s_nxt.lock_out = lock_s;
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.scl_q <= 1'b1;
            s_r.sda_q <= 1'b1;
            s_r.por <= 1'b1;
            s_r.bypass_en <= 1'b1;
            s_r.lock_out <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sda_out = s_r.sda_o;
    assign sda_oe = s_r.sda_oe;
    assign synth_div = s_r.synth_div;
    assign ref_div_sel = s_r.ref_div_sel;
    assign rf_gain_hi = s_r.rf_gain_hi;
    assign filter_ref_div = s_r.filter_ref_div;
    assign filter_width_code = s_r.filter_width_code;
    assign power_down = s_r.power_down;
    assign bypass_en = s_r.bypass_en;
    assign bypass_pd = s_r.bypass_pd;
    assign lo_band_sel = s_r.lo_band_sel;
    assign lock_out = s_r.lock_out;
    assign port0_on = s_r.port0_on;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence addr_hit;
        !start_cond && !stop_cond && s_r.st == ST_ADDR && scl_fall && s_r.cnt == BYTE_BITS && addr_match;
    endsequence

    sequence byte_in;
        !start_cond && !stop_cond && s_r.st == ST_WRITE && scl_fall && s_r.cnt == BYTE_BITS;
    endsequence

    sequence master_nack;
        !start_cond && !stop_cond && s_r.st == ST_RACK && scl_fall && !s_r.ackd;
    endsequence

    sequence last_bit_out;
        !start_cond && !stop_cond && s_r.st == ST_READ && scl_fall && s_r.cnt == LAST_BIT;
    endsequence

    sequence rd_load;
        !start_cond && !stop_cond && s_r.st == ST_ACK && scl_fall && s_r.rw;
    endsequence

    a_addr_ack: assert property (addr_hit |=> s_r.sda_oe && s_r.st == ST_ACK)
        else $error("address not acknowledged");
    a_rw_mode: assert property (addr_hit |=> s_r.rw == $past(s_r.shift[0]))
        else $error("direction bit not taken");
    a_data_ack: assert property (byte_in |=> s_r.sda_oe && s_r.wr_stb && s_r.wr_data == $past(s_r.shift))
        else $error("data byte not acknowledged");
    a_nack_stop: assert property (master_nack |=> s_r.st == ST_IDLE && !s_r.sda_oe)
        else $error("read not ended on missing ack");
    a_pd_or: assert property (##1 power_down == $past(sleep_s || regs[IDX_CTRL][BIT_PD]))
        else $error("power-down not the OR of pin and bit");
    a_bypass_free: assert property (##1 bypass_en == $past(regs[IDX_CTRL][BIT_BYPASS]) && bypass_pd == !bypass_en)
        else $error("bypass not following its bit");
    a_lock_pin: assert property (##1 lock_out == $past(lock_s) && status[STAT_LOCK] == lock_s)
        else $error("lock pin or status bit wrong");
    a_band_auto: assert property (##1 lo_band_sel == band_of(synth_div))
        else $error("band not derived from divider");
    a_gain_step: assert property (##1 rf_gain_hi == $past(regs[IDX_GAIN][BIT_RF_GAIN]))
        else $error("gain step not following its bit");
    a_ack_release: assert property (last_bit_out |=> !s_r.sda_oe && s_r.st == ST_RACK)
        else $error("data line not released for master ack");
    a_idle_quiet: assert property (s_r.st == ST_IDLE |=> !s_r.sda_oe)
        else $error("data line driven while idle");
    a_regs_kept: assert property (!s_r.wr_stb |=> $stable(regs))
        else $error("settings changed without a write");
    a_status_load: assert property (rd_load |=> s_r.tx == $past(status) && s_r.st == ST_READ)
        else $error("status byte not loaded for read");
endmodule // tsc_ctrl
`default_nettype wire

/* File: verification/tsc_master_model.sv */
// two-wire bus master model driving the link clock and data pull-down
// assumes a pull-up on data and that the caller waits for each task to end
`timescale 1ns/100ps
`default_nettype none
module tsc_master_model (
    input wire logic clk,   // system clock, paces the model
    input wire logic sda,   // resolved data line level
    output logic scl,       // link clock, high while idle
    output logic sda_low    // high while the master pulls data low
);
    // ==========================================================
    // bus conditions and bit cycles, 8 clk per link clock period
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic start();
        sda_low <= 1'b0;
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda_low <= 1'b1;
        repeat (4) @(posedge clk);
        scl <= 1'b0;
    endtask

    task automatic stop();
        repeat (2) @(posedge clk);
        sda_low <= 1'b1;
        repeat (2) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda_low <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic bit_cycle(input logic b, output logic r);
        repeat (2) @(posedge clk);
        sda_low <= ~b;
        repeat (2) @(posedge clk);
        scl <= 1'b1;
        repeat (2) @(posedge clk);
        r = sda;
        repeat (2) @(posedge clk);
        scl <= 1'b0;
    endtask

    // address byte carries the direction in its low bit
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(d[i], r);
        end
        bit_cycle(1'b1, r);
        ack = ~r;
    endtask

    // master pulls data low in the slot to ask for another status byte
    task automatic read_byte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, d[i]);
        end
        bit_cycle(~mack, r);
    endtask
endmodule // tsc_master_model
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench of the tuner serial control logic
// assumes tsc_pkg compiled first; data line has a pull-up
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    import tsc_pkg::*;
    // ==========================================================
    // signals and instances
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic id_level_hi = 1'b0, id_level_lo = 1'b0, sleep_in = 1'b0, lock_in = 1'b0;
    logic sda_out, sda_oe, rf_gain_hi, power_down, bypass_en, bypass_pd, lock_out, port0_on;
    logic [W_DIV-1:0] synth_div;
    logic [W_REF_SEL-1:0] ref_div_sel;
    logic [W_FREF-1:0] filter_ref_div;
    logic [W_FBW-1:0] filter_width_code;
    logic [1:0] lo_band_sel;
    wire logic scl_w, m_low, sda_w;
    int n_mismatch = 0, checked = 0, cycles = 0;
    logic [7:0] a;

    assign sda_w = ~(m_low | sda_oe);
    always #20 clk = ~clk;

    tsc_master_model u_master (.clk(clk), .sda(sda_w), .scl(scl_w), .sda_low(m_low));
    tsc_ctrl u_dut (.clk(clk), .reset(reset), .scl_in(scl_w), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe), .id_level_hi(id_level_hi), .id_level_lo(id_level_lo), .sleep_in(sleep_in),
        .lock_in(lock_in), .synth_div(synth_div), .ref_div_sel(ref_div_sel), .rf_gain_hi(rf_gain_hi),
        .filter_ref_div(filter_ref_div), .filter_width_code(filter_width_code), .power_down(power_down),
        .bypass_en(bypass_en), .bypass_pd(bypass_pd), .lo_band_sel(lo_band_sel), .lock_out(lock_out),
        .port0_on(port0_on));

    // ==========================================================
    // expectations, transfers and closing
    function automatic logic [7:0] stat(input logic por, input logic lk);
        return {por, lk, 6'h00};
    endfunction

    function automatic logic [1:0] band(input logic [14:0] v);
        return (v < BAND_MID_MIN) ? BAND_LO : (v < BAND_HI_MIN) ? BAND_MID : BAND_HI;
    endfunction

    task automatic wr(input logic [7:0] b0, input logic [7:0] b1);
        logic ack;
        u_master.start();
        u_master.write_byte(a, ack);
        `CHK(ack, 1'b1)
        u_master.write_byte(b0, ack);
        `CHK(ack, 1'b1)
        u_master.write_byte(b1, ack);
        `CHK(ack, 1'b1)
        u_master.stop();
        repeat (6) @(posedge clk);
    endtask

    task automatic rd(input logic por, input logic lk);
        logic ack;
        logic [7:0] d;
        u_master.start();
        u_master.write_byte(a | 8'h01, ack);
        `CHK(ack, 1'b1)
        u_master.read_byte(1'b1, d);
        `CHK(d, stat(por, lk))
        u_master.read_byte(1'b0, d);
        `CHK(d, stat(por, lk))
        u_master.read_byte(1'b1, d);
        `CHK(d, 8'hff)
        u_master.stop();
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        logic ack, g, p0, lk;
        logic [14:0] dv;
        logic [4:0] fr, rs;
        logic [5:0] fw;
        logic [1:0] sel;
        void'($urandom(15728));
        a = 8'hc0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK(bypass_en, 1'b1)
        `CHK(bypass_pd, 1'b0)
        `CHK(lock_out, 1'b0)
        `CHK(power_down, 1'b0)
        `CHK(sda_out, 1'b0)
        lk = 1'($urandom);
        lock_in <= lk;
        repeat (6) @(posedge clk);
        `CHK(lock_out, lk)
        rd(1'b1, lk);
        lk = ~lk;
        lock_in <= lk;
        repeat (6) @(posedge clk);
        rd(1'b0, lk);
        for (int i = 0; i < 4; i++) begin
            sel = 2'(i);
            id_level_hi <= sel[1];
            id_level_lo <= sel[0];
            repeat (6) @(posedge clk);
            a = 8'hc0 | {5'h00, sel, 1'b0};
            g = 1'($urandom);
            p0 = 1'($urandom);
            rs = 5'($urandom % 29);
            wr({2'b10, g, 5'h00}, {p0, 2'b00, rs});
            `CHK(rf_gain_hi, g)
            `CHK(ref_div_sel, rs)
            `CHK(port0_on, p0)
            u_master.start();
            u_master.write_byte(8'hc0 | {5'h00, sel + 2'h1, 1'b0}, ack);
            u_master.stop();
            `CHK(ack, 1'b0)
        end
        for (int i = 0; i < 3; i++) begin
            dv = (i == 0) ? 15'h0fff : (i == 1) ? 15'h3000 : 15'($urandom);
            wr({1'b0, dv[14:8]}, dv[7:0]);
            `CHK(synth_div, dv)
            `CHK(lo_band_sel, band(dv))
        end
        fr = 5'd4 + 5'($urandom % 24);
        fw = 6'($urandom % 63);
        wr(8'hc2, {3'b000, fr});
        wr(8'hd0, {2'b00, fw});
        `CHK(filter_ref_div, fr)
        `CHK(filter_width_code, fw)
        for (int i = 0; i < 4; i++) begin
            sleep_in <= i[0];
            wr({6'b110000, 1'b1, i[1]}, {3'b000, fr});
            `CHK(power_down, i[0] | i[1])
            `CHK(bypass_en, 1'b1)
            `CHK(bypass_pd, 1'b0)
            `CHK(filter_width_code, fw)
            `CHK(synth_div, dv)
        end
        wr(8'hc0, {3'b000, fr});
        `CHK(bypass_en, 1'b0)
        `CHK(bypass_pd, 1'b1)
        results();
    end
endmodule // tb_top
`default_nettype wire
